// ===== logic/scbt_chan_master.sv
`timescale 1ns/1ps
module scbt_chan_master (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       req,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] data,
  output logic            busy,
  output logic            done,
  output logic            nack,
  output logic            lost,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe
);
  typedef struct packed {
    scbt_pkg::scbt_px_e st;
    logic [1:0]         scl_s;
    logic [1:0]         sda_s;
    logic [7:0]         div;
    logic [7:0]         free;
    logic [1:0]         ph;
    logic [3:0]         bitn;
    logic               byten;
    logic [7:0]         shf;
    logic               ackn;
    logic [6:0]         addr;
    logic [7:0]         data;
    logic               scl_oe;
    logic               sda_oe;
    logic               done;
    logic               nack;
    logic               lost;
  } scbt_px_s;

  scbt_px_s st_ff;
  scbt_px_s nxt_st;
  logic     tick;
  logic     scl_hi;
  logic     sda_hi;

  assign tick   = (st_ff.div == 8'h00);
  assign scl_hi = st_ff.scl_s[1];
  assign sda_hi = st_ff.sda_s[1];

  always_comb
  begin
    nxt_st       = st_ff;
    nxt_st.scl_s = {st_ff.scl_s[0], scl_i};
    nxt_st.sda_s = {st_ff.sda_s[0], sda_i};
    nxt_st.div   = tick ? scbt_pkg::QTR_CYC - 8'h01 : st_ff.div - 8'h01;
    nxt_st.done  = 1'b0;
    nxt_st.nack  = 1'b0;
    nxt_st.lost  = 1'b0;
    case (st_ff.st)
      scbt_pkg::P_IDLE:
      begin
        if (req)
        begin
          nxt_st.addr = addr;
          nxt_st.data = data;
          nxt_st.free = 8'h00;
          nxt_st.st   = scbt_pkg::P_FREE;
        end
      end
      scbt_pkg::P_FREE:
      begin
        // Retry only after both lines have stood high for the bus free time [R10]
        nxt_st.free = (scl_hi && sda_hi) ? st_ff.free + 8'h01 : 8'h00;
        if (st_ff.free >= scbt_pkg::BUS_FREE_CYC && tick)
        begin
          nxt_st.st = scbt_pkg::P_START;
          nxt_st.ph = 2'h0;
        end
      end
      scbt_pkg::P_START:
      begin
        if (tick)
        begin
          nxt_st.ph = st_ff.ph + 2'h1;
          if (st_ff.ph == 2'h0)
            nxt_st.sda_oe = 1'b1;  // [R2]
          else
          begin
            nxt_st.scl_oe = 1'b1;
            nxt_st.st     = scbt_pkg::P_BIT;
            nxt_st.ph     = 2'h0;
            nxt_st.bitn   = 4'h0;
            nxt_st.byten  = 1'b0;
            nxt_st.shf    = {st_ff.addr, 1'b0};
          end
        end
      end
      scbt_pkg::P_BIT:
      begin
        if (tick)
        begin
          case (st_ff.ph)
            2'h0:
            begin
              nxt_st.sda_oe = (st_ff.bitn == scbt_pkg::BITS_BYTE) ? 1'b0 : ~st_ff.shf[7];
              nxt_st.ph     = 2'h1;
            end
            2'h1:
            begin
              nxt_st.scl_oe = 1'b0;
              nxt_st.ph     = 2'h2;
            end
            2'h2:
            begin
              // Held here while another party stretches SCL
              if (scl_hi)
              begin
                if (st_ff.bitn != scbt_pkg::BITS_BYTE && !st_ff.sda_oe && !sda_hi)
                begin
                  nxt_st.sda_oe = 1'b0;  // [R10]
                  nxt_st.scl_oe = 1'b0;
                  nxt_st.lost   = 1'b1;
                  nxt_st.free   = 8'h00;
                  nxt_st.st     = scbt_pkg::P_FREE;
                end
                else
                begin
                  nxt_st.ackn = sda_hi;
                  nxt_st.ph   = 2'h3;
                end
              end
            end
            default:
            begin
              nxt_st.scl_oe = 1'b1;
              nxt_st.ph     = 2'h0;
              if (st_ff.bitn == scbt_pkg::BITS_BYTE)
              begin
                nxt_st.bitn  = 4'h0;
                nxt_st.byten = 1'b1;
                nxt_st.shf   = st_ff.data;
                if (st_ff.ackn || st_ff.byten)
                  nxt_st.st = scbt_pkg::P_STOP;
              end
              else
              begin
                nxt_st.bitn = st_ff.bitn + 4'h1;
                nxt_st.shf  = {st_ff.shf[6:0], 1'b0};
              end
            end
          endcase
        end
      end
      default:
      begin
        if (tick)
        begin
          case (st_ff.ph)
            2'h0:
            begin
              nxt_st.sda_oe = 1'b1;
              nxt_st.ph     = 2'h1;
            end
            2'h1:
            begin
              nxt_st.scl_oe = 1'b0;
              nxt_st.ph     = 2'h2;
            end
            2'h2:
            begin
              if (scl_hi)
              begin
                nxt_st.sda_oe = 1'b0;  // [R3]
                nxt_st.ph     = 2'h3;
              end
            end
            default:
            begin
              nxt_st.done = 1'b1;
              nxt_st.nack = st_ff.ackn;
              nxt_st.st   = scbt_pkg::P_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      nxt_hold: st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign busy   = (st_ff.st != scbt_pkg::P_IDLE);
  assign done   = st_ff.done;
  assign nack   = st_ff.nack;
  assign lost   = st_ff.lost;
  assign scl_o  = scbt_pkg::LINE_LOW;  // [R21]
  assign sda_o  = scbt_pkg::LINE_LOW;
  assign scl_oe = st_ff.scl_oe;
  assign sda_oe = st_ff.sda_oe;

  property p_arb_lost;
    @(posedge clk) disable iff (srst)
    (st_ff.st == scbt_pkg::P_BIT && tick && st_ff.ph == 2'h2 && scl_hi && !sda_hi && !st_ff.sda_oe
     && st_ff.bitn != scbt_pkg::BITS_BYTE)
    |=> lost && !sda_oe && !scl_oe && st_ff.st == scbt_pkg::P_FREE;
  endproperty
  a_arb_lost: assert property (p_arb_lost) else $error("proxy master kept driving after arbitration loss"); // [R10]

  property p_retry_waits;
    @(posedge clk) disable iff (srst)
    lost |-> ##1 (st_ff.st == scbt_pkg::P_FREE) [*8];
  endproperty
  a_retry_waits: assert property (p_retry_waits) else $error("retry started before bus free time"); // [R10]

  c_lost: cover property (@(posedge clk) disable iff (srst) lost);
  c_done: cover property (@(posedge clk) disable iff (srst) done && !nack);
endmodule

// ===== logic/scbt_pkg.sv
// Rules from the document for this block
// R1 - Strap level picks address 0x0C..0x1A, step two
// R2 - Start: SDA falls while SCL high
// R3 - Stop: SDA rises while SCL high
// R4 - Matching address gets ACK, SDA pulled low
// R5 - Other address: SDA released, NACK by pullup
// R6 - Each written data byte is acknowledged
// R7 - Reading master ACKs bytes, NACKs last, stops
// R8 - Transactions open with start, close with stop
// R9 - Local master tolerates SCL held low
// R10 - Proxy master backs off on lost arbitration, retries
// R11 - All sharing masters support multi-master arbitration
// R12 - Target addresses need several one bits
// R13 - Avoid colliding repeated start or stop
// R14 - Local and remote register access arbitrated
// R15 - Remote target access one direction only
// R16 - One channel direction active, explicit handoff
// R17 - Mailbox register may pass channel control
// R18 - Older partners: single controller or local-only
// R19 - Older partners: shared register for handoff only
// R20 - Control bit selects strap or programmed address
// R21 - SDA and SCL only ever driven low
package scbt_pkg;
  localparam int          CLK_HZ        = 20_000_000;
  localparam int          STRAP_W       = 3;
  localparam logic [6:0]  STRAP_BASE    = 7'h0C;
  localparam logic [6:0]  STRAP_STEP    = 7'h02;
  localparam logic [1:0]  STRAP_WAIT    = 2'h3;
  localparam int          REG_N         = 8;
  localparam int          REG_IDX_W     = 3;
  localparam logic [2:0]  REG_ID        = 3'h0;
  localparam int          ID_SEL_BIT    = 0;
  localparam logic [3:0]  BITS_BYTE     = 4'h8;
  localparam logic [3:0]  LAST_BIT      = 4'h7;
  localparam logic        LINE_LOW      = 1'b0;
  // Proxy master quarter bit time and bus free time
  localparam int          QTR_NS        = 2500;
  localparam int          BUS_FREE_NS   = 4700;
  localparam logic [7:0]  QTR_CYC       = 8'(QTR_NS / (1_000_000_000 / CLK_HZ));
  localparam logic [7:0]  BUS_FREE_CYC  = 8'((BUS_FREE_NS * (CLK_HZ / 1_000_000) + 999) / 1000);

  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_ACK, T_WR, T_RD, T_RACK} scbt_tgt_e;
  typedef enum logic [2:0] {P_IDLE, P_FREE, P_START, P_BIT, P_STOP} scbt_px_e;

  function automatic logic [6:0] strap_addr(input logic [2:0] lvl);
    strap_addr = 7'(STRAP_BASE + STRAP_STEP * {4'h0, lvl});
  endfunction
endpackage

// ===== logic/scbt_target.sv
`timescale 1ns/1ps
module scbt_target (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [2:0] strap_level,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic [6:0]      dev_addr,
  input  wire logic       rem_req,
  input  wire logic       rem_we,
  input  wire logic [2:0] rem_addr,
  input  wire logic [7:0] rem_wdata,
  output logic            rem_ack,
  output logic [7:0]      rem_rdata,
  input  wire logic       chan_req,
  input  wire logic [6:0] chan_addr,
  input  wire logic [7:0] chan_data,
  output logic            chan_busy,
  output logic            chan_done,
  output logic            chan_nack,
  output logic            chan_lost,
  input  wire logic       chan_scl_i,
  output logic            chan_scl_o,
  output logic            chan_scl_oe,
  input  wire logic       chan_sda_i,
  output logic            chan_sda_o,
  output logic            chan_sda_oe
);
  typedef struct packed {
    scbt_pkg::scbt_tgt_e         st;
    logic [1:0]                  scl_s;
    logic [1:0]                  sda_s;
    logic [1:0][2:0]             strap_s;
    logic                        scl_p;
    logic                        sda_p;
    logic [1:0]                  cap_cnt;
    logic                        cap_done;
    logic [6:0]                  strap_addr;
    logic [7:0]                  shf;
    logic [3:0]                  bitcnt;
    logic                        rw;
    logic                        first;
    logic [2:0]                  ptr;
    logic                        ackn;
    logic                        sda_oe;
    logic                        rem_ack;
    logic [7:0]                  rem_rdata;
    logic [scbt_pkg::REG_N-1:0][7:0] regs;
  } scbt_tgt_s;

  scbt_tgt_s  st_ff;
  scbt_tgt_s  nxt_st;
  logic       scl_hi;
  logic       sda_hi;
  logic       scl_r;
  logic       scl_f;
  logic       start_ev;
  logic       stop_ev;
  logic [6:0] my_addr;
  logic       match;
  logic       loc_acc;

  assign scl_hi   = st_ff.scl_s[1];
  assign sda_hi   = st_ff.sda_s[1];
  assign scl_r    = scl_hi && !st_ff.scl_p;
  assign scl_f    = !scl_hi && st_ff.scl_p;
  assign start_ev = scl_hi && st_ff.scl_p && st_ff.sda_p && !sda_hi;  // [R2]
  assign stop_ev  = scl_hi && st_ff.scl_p && !st_ff.sda_p && sda_hi;  // [R3]
  // Programmed address only when the select bit of the ID register is set [R20]
  assign my_addr  = st_ff.regs[scbt_pkg::REG_ID][scbt_pkg::ID_SEL_BIT] ?
                    st_ff.regs[scbt_pkg::REG_ID][7:1] : st_ff.strap_addr;
  assign match    = (st_ff.shf[7:1] == my_addr);

  always_comb
  begin
    nxt_st           = st_ff;
    loc_acc          = 1'b0;
    nxt_st.scl_s     = {st_ff.scl_s[0], scl_i};
    nxt_st.sda_s     = {st_ff.sda_s[0], sda_i};
    nxt_st.strap_s   = {st_ff.strap_s[0], strap_level};
    nxt_st.scl_p     = scl_hi;
    nxt_st.sda_p     = sda_hi;
    nxt_st.rem_ack   = 1'b0;
    // Strap is caught once its synchroniser has filled after reset
    if (!st_ff.cap_done)
    begin
      nxt_st.cap_cnt = st_ff.cap_cnt + 2'h1;
      if (st_ff.cap_cnt == scbt_pkg::STRAP_WAIT)
      begin
        nxt_st.cap_done                       = 1'b1;
        nxt_st.strap_addr                     = scbt_pkg::strap_addr(st_ff.strap_s[1]);  // [R1]
        nxt_st.regs[scbt_pkg::REG_ID][7:1]    = scbt_pkg::strap_addr(st_ff.strap_s[1]);
      end
    end
    if (stop_ev)
    begin
      nxt_st.st     = scbt_pkg::T_IDLE;  // [R8]
      nxt_st.sda_oe = 1'b0;
    end
    else if (start_ev)
    begin
      nxt_st.st     = scbt_pkg::T_ADDR;  // [R8]
      nxt_st.bitcnt = 4'h0;
      nxt_st.sda_oe = 1'b0;
    end
    else
    begin
      case (st_ff.st)
        scbt_pkg::T_ADDR, scbt_pkg::T_WR:
        begin
          if (scl_r && st_ff.bitcnt != scbt_pkg::BITS_BYTE)
          begin
            nxt_st.shf    = {st_ff.shf[6:0], sda_hi};
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
          end
          else if (scl_f && st_ff.bitcnt == scbt_pkg::BITS_BYTE)
          begin
            nxt_st.bitcnt = 4'h0;
            if (st_ff.st == scbt_pkg::T_ADDR)
            begin
              if (match)
              begin
                nxt_st.sda_oe = 1'b1;  // [R4]
                nxt_st.st     = scbt_pkg::T_ACK;
                nxt_st.rw     = st_ff.shf[0];
                nxt_st.first  = 1'b1;
                if (st_ff.shf[0])
                begin
                  loc_acc          = 1'b1;  // [R14]
                  nxt_st.shf       = st_ff.regs[st_ff.ptr];
                  nxt_st.ptr       = st_ff.ptr + 3'h1;
                end
              end
              else
                nxt_st.st = scbt_pkg::T_IDLE;  // [R5]
            end
            else
            begin
              nxt_st.sda_oe = 1'b1;  // [R6]
              nxt_st.st     = scbt_pkg::T_ACK;
              nxt_st.first  = 1'b0;
              if (st_ff.first)
                nxt_st.ptr = st_ff.shf[scbt_pkg::REG_IDX_W-1:0];
              else
              begin
                loc_acc                = 1'b1;  // [R14]
                nxt_st.regs[st_ff.ptr] = st_ff.shf;
                nxt_st.ptr             = st_ff.ptr + 3'h1;
              end
            end
          end
        end
        scbt_pkg::T_ACK:
        begin
          if (scl_f)
          begin
            nxt_st.st     = st_ff.rw ? scbt_pkg::T_RD : scbt_pkg::T_WR;
            nxt_st.sda_oe = st_ff.rw ? ~st_ff.shf[7] : 1'b0;
          end
        end
        scbt_pkg::T_RD:
        begin
          if (scl_f)
          begin
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
            nxt_st.shf    = {st_ff.shf[6:0], 1'b0};
            nxt_st.sda_oe = ~st_ff.shf[6];
            if (st_ff.bitcnt == scbt_pkg::LAST_BIT)
            begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.st     = scbt_pkg::T_RACK;
            end
          end
        end
        scbt_pkg::T_RACK:
        begin
          if (scl_r)
          begin
            nxt_st.ackn = sda_hi;
            if (!sda_hi)
            begin
              loc_acc    = 1'b1;  // [R14]
              nxt_st.shf = st_ff.regs[st_ff.ptr];
              nxt_st.ptr = st_ff.ptr + 3'h1;
            end
          end
          else if (scl_f)
          begin
            // A NACKed byte ends the read; the master follows with a stop
            nxt_st.bitcnt = 4'h0;
            nxt_st.st     = st_ff.ackn ? scbt_pkg::T_IDLE : scbt_pkg::T_RD;
            nxt_st.sda_oe = st_ff.ackn ? 1'b0 : ~st_ff.shf[7];
          end
        end
        default:
        begin
          nxt_st.sda_oe = 1'b0;
        end
      endcase
    end
    // Remote side yields to a bus access in the same cycle and is served next time
    if (rem_req && !st_ff.rem_ack && !loc_acc && st_ff.cap_done)
    begin
      nxt_st.rem_ack   = 1'b1;  // [R14]
      nxt_st.rem_rdata = st_ff.regs[rem_addr];
      if (rem_we)
        nxt_st.regs[rem_addr] = rem_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign sda_o     = scbt_pkg::LINE_LOW;  // [R21]
  assign sda_oe    = st_ff.sda_oe;
  assign dev_addr  = my_addr;
  assign rem_ack   = st_ff.rem_ack;
  assign rem_rdata = st_ff.rem_rdata;

  scbt_chan_master u_chan (
    .clk    (clk),
    .srst   (srst),
    .req    (chan_req),
    .addr   (chan_addr),
    .data   (chan_data),
    .busy   (chan_busy),
    .done   (chan_done),
    .nack   (chan_nack),
    .lost   (chan_lost),
    .scl_i  (chan_scl_i),
    .scl_o  (chan_scl_o),
    .scl_oe (chan_scl_oe),
    .sda_i  (chan_sda_i),
    .sda_o  (chan_sda_o),
    .sda_oe (chan_sda_oe)
  );

  property p_strap;
    @(posedge clk) disable iff (srst)
    $rose(st_ff.cap_done) |-> st_ff.strap_addr == scbt_pkg::strap_addr($past(st_ff.strap_s[1]));
  endproperty
  a_strap: assert property (p_strap) else $error("strap address wrong"); // [R1]

  property p_start;
    @(posedge clk) disable iff (srst)
    start_ev && !stop_ev |=> st_ff.st == scbt_pkg::T_ADDR && !sda_oe;
  endproperty
  a_start: assert property (p_start) else $error("start not taken"); // [R2]

  property p_stop;
    @(posedge clk) disable iff (srst)
    stop_ev |=> st_ff.st == scbt_pkg::T_IDLE && !sda_oe;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken"); // [R3]

  property p_addr_ack;
    @(posedge clk) disable iff (srst)
    st_ff.st == scbt_pkg::T_ADDR && scl_f && st_ff.bitcnt == scbt_pkg::BITS_BYTE && match
      && !start_ev && !stop_ev |=> sda_oe && st_ff.st == scbt_pkg::T_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged"); // [R4]

  property p_addr_nack;
    @(posedge clk) disable iff (srst)
    st_ff.st == scbt_pkg::T_ADDR && !match && scl_f && st_ff.bitcnt == scbt_pkg::BITS_BYTE
    |=> !sda_oe;
  endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("foreign address acknowledged"); // [R5]

  property p_data_ack;
    @(posedge clk) disable iff (srst)
    st_ff.st == scbt_pkg::T_WR && scl_f && st_ff.bitcnt == scbt_pkg::BITS_BYTE
      && !start_ev && !stop_ev |=> sda_oe;
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("written byte not acknowledged"); // [R6]

  property p_idle_hold;
    @(posedge clk) disable iff (srst)
    st_ff.st == scbt_pkg::T_IDLE && !start_ev |=> st_ff.st == scbt_pkg::T_IDLE && !sda_oe;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("left idle without start"); // [R8]

  property p_rem_yield;
    @(posedge clk) disable iff (srst)
    rem_req && loc_acc |=> !rem_ack ##1 (rem_ack || !$past(rem_req));
  endproperty
  a_rem_yield: assert property (p_rem_yield) else $error("remote access not arbitrated"); // [R14]

  property p_sel;
    @(posedge clk) disable iff (srst)
    !st_ff.regs[scbt_pkg::REG_ID][scbt_pkg::ID_SEL_BIT] |-> dev_addr == st_ff.strap_addr;
  endproperty
  a_sel: assert property (p_sel) else $error("strap address not in use"); // [R20]

  c_write: cover property (@(posedge clk) disable iff (srst) st_ff.st == scbt_pkg::T_WR && !st_ff.first && scl_f);
  c_read:  cover property (@(posedge clk) disable iff (srst) st_ff.st == scbt_pkg::T_RACK && scl_r && !sda_hi);
  c_clash: cover property (@(posedge clk) disable iff (srst) rem_req && loc_acc);
endmodule

// ===== testbench/scbt_host_model.sv
`timescale 1ns/1ps
module scbt_host_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_oe,
  output logic      sda_oe
);
  // SDA moves late in the low phase, well after the target's three-cycle turnaround
  localparam int SET_NS  = 225;
  localparam int RISE_NS = 25;
  localparam int SMP_NS  = 75;

  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  task automatic bit_io(input logic b, output logic s);
    #SET_NS sda_oe = !b;
    #RISE_NS scl_oe = 1'b0;
    wait (scl === 1'b1);
    #SMP_NS s = sda;
    #SMP_NS scl_oe = 1'b1;
  endtask

  task automatic start;
    #SET_NS sda_oe = 1'b0;
    #RISE_NS scl_oe = 1'b0;
    wait (scl === 1'b1);
    #100 sda_oe = 1'b1;
    #100 scl_oe = 1'b1;
  endtask

  task automatic stop;
    #SET_NS sda_oe = 1'b1;
    #RISE_NS scl_oe = 1'b0;
    wait (scl === 1'b1);
    #100 sda_oe = 1'b0;
    #100;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask

  task automatic rbyte(output logic [7:0] d, input logic more);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(!more, s);
  endtask
endmodule

// ===== testbench/test_serial_control_bus_target.sv
`timescale 1ns/1ps
module test_serial_control_bus_target;
  localparam int LIMIT = 20000;
  logic       clk;
  logic       srst;
  logic [2:0] strap_level;
  logic       rem_req;
  logic       rem_we;
  logic [2:0] rem_addr;
  logic [7:0] rem_wdata;
  logic       chan_req;
  logic [6:0] chan_addr;
  logic [7:0] chan_data;
  logic       sda_o, sda_oe, rem_ack, chan_busy, chan_done, chan_nack, chan_lost;
  logic       chan_scl_o, chan_scl_oe, chan_sda_o, chan_sda_oe, h_scl_oe, h_sda_oe;
  logic [6:0] dev_addr;
  logic [7:0] rem_rdata;
  logic       ch_ack, ch_grab, od_bad;
  int         ch_cnt, cyc, error_cnt, cmp_count;
  // Both buses have pull-ups: a line is low only while some party pulls it
  wire        scl_w      = !h_scl_oe;
  wire        sda_w      = !(h_sda_oe | sda_oe);
  wire        ch_pull    = (ch_ack && (ch_cnt == 9 || ch_cnt == 18)) || (ch_grab && ch_cnt == 1);
  wire        chan_scl_w = !chan_scl_oe;
  wire        chan_sda_w = !(chan_sda_oe | ch_pull);

  scbt_target dut (.clk(clk), .srst(srst), .strap_level(strap_level), .scl_i(scl_w), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .dev_addr(dev_addr), .rem_req(rem_req), .rem_we(rem_we),
    .rem_addr(rem_addr), .rem_wdata(rem_wdata), .rem_ack(rem_ack), .rem_rdata(rem_rdata),
    .chan_req(chan_req), .chan_addr(chan_addr), .chan_data(chan_data), .chan_busy(chan_busy),
    .chan_done(chan_done), .chan_nack(chan_nack), .chan_lost(chan_lost), .chan_scl_i(chan_scl_w),
    .chan_scl_o(chan_scl_o), .chan_scl_oe(chan_scl_oe), .chan_sda_i(chan_sda_w),
    .chan_sda_o(chan_sda_o), .chan_sda_oe(chan_sda_oe));
  scbt_host_model host (.scl(scl_w), .sda(sda_w), .scl_oe(h_scl_oe), .sda_oe(h_sda_oe));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Bit counter of the far target on the channel: restarts at each start
  always @(negedge chan_sda_w) if (chan_scl_w) ch_cnt = 0;
  always @(negedge chan_scl_w) ch_cnt = ch_cnt + 1;

  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 3 && (sda_o !== 1'b0 || chan_sda_o !== 1'b0 || chan_scl_o !== 1'b0)) od_bad = 1'b1;
    if (cyc == LIMIT)
    begin
      error_cnt++;
      stop_test;
    end
  end

  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic rem_acc(input logic we, input logic [2:0] a, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk);
    #1;
    rem_req = 1'b1;
    rem_we = we;
    rem_addr = a;
    rem_wdata = wd;
    for (int i = 0; i < 8 && rem_ack !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    rd = rem_rdata;
    check("rem_ack", {7'h0, rem_ack}, 8'h01);
    rem_req = 1'b0;
  endtask

  task automatic rchk(input logic [2:0] r, input logic [7:0] exp);
    logic [7:0] d;
    rem_acc(1'b0, r, 8'h00, d);
    check("reg", d, exp);
  endtask

  task automatic hw(input logic [7:0] d, input logic exp);
    logic a;
    host.wbyte(d, a);
    check("ack", {7'h0, a}, {7'h0, exp});
  endtask

  task automatic t_strap;
    for (int lv = 7; lv >= 0; lv--)
    begin
      @(posedge clk);
      #1;
      srst = 1'b1;
      strap_level = 3'(lv);
      repeat (5) @(posedge clk);
      #1;
      srst = 1'b0;
      repeat (6) @(posedge clk);
      #1;
      check("dev_addr", {1'b0, dev_addr}, 8'h0C + 8'(2 * lv));
      check("sda_oe", {7'h0, sda_oe}, 8'h00);
    end
  endtask

  task automatic t_write;
    logic [7:0] d;
    fork
      begin
        host.start;
        hw(8'h18, 1'b1);
        hw(8'h02, 1'b1);
        hw(8'hA5, 1'b1);
        hw(8'h5A, 1'b1);
        host.stop;
      end
      for (int i = 0; i < 100; i++) rem_acc(1'b1, 3'h6, 8'(i), d);
    join
    rchk(3'h2, 8'hA5);
    rchk(3'h3, 8'h5A);
    rchk(3'h6, 8'h63);
  endtask

  task automatic t_read;
    logic [7:0] d;
    // Remote side fills the registers alone before the local master reads them
    rem_acc(1'b1, 3'h4, 8'h3C, d);
    rem_acc(1'b1, 3'h5, 8'hC3, d);
    host.start;
    hw(8'h18, 1'b1);
    hw(8'h04, 1'b1);
    host.start;
    hw(8'h19, 1'b1);
    host.rbyte(d, 1'b1);
    check("rd0", d, 8'h3C);
    host.rbyte(d, 1'b0);
    check("rd1", d, 8'hC3);
    host.stop;
    repeat (4) @(posedge clk);
    #1;
    check("sda_oe", {7'h0, sda_oe}, 8'h00);
  endtask

  task automatic t_nomatch;
    host.start;
    hw(8'h1A, 1'b0);
    hw(8'h02, 1'b0);
    host.stop;
    rchk(3'h2, 8'hA5);
  endtask

  task automatic t_prog;
    logic [7:0] d;
    rem_acc(1'b1, 3'h0, 8'h45, d);
    @(posedge clk);
    #1;
    check("dev_addr", {1'b0, dev_addr}, 8'h22);
    host.start;
    hw(8'h44, 1'b1);
    hw(8'h07, 1'b1);
    hw(8'h77, 1'b1);
    host.stop;
    rchk(3'h7, 8'h77);
    host.start;
    hw(8'h18, 1'b0);
    host.stop;
    rem_acc(1'b1, 3'h0, 8'h18, d);
    @(posedge clk);
    #1;
    check("dev_addr", {1'b0, dev_addr}, 8'h0C);
  endtask

  task automatic chan_xfer(input logic [6:0] a, input logic [7:0] d, input logic e_nack, input logic e_lost);
    logic nk, ls, dn;
    nk = 1'b0;
    ls = 1'b0;
    dn = 1'b0;
    @(posedge clk);
    #1;
    chan_req = 1'b1;
    chan_addr = a;
    chan_data = d;
    @(posedge clk);
    #1;
    chan_req = 1'b0;
    check("chan_busy", {7'h0, chan_busy}, 8'h01);
    for (int i = 0; i < 9000 && !dn; i++)
    begin
      @(posedge clk);
      #1;
      if (chan_lost === 1'b1)
      begin
        ls = 1'b1;
        ch_grab = 1'b0;
      end
      if (chan_done === 1'b1)
      begin
        dn = 1'b1;
        nk = chan_nack;
      end
    end
    check("chan_done", {7'h0, dn}, 8'h01);
    check("chan_nack", {7'h0, nk}, {7'h0, e_nack});
    check("chan_lost", {7'h0, ls}, {7'h0, e_lost});
  endtask

  task automatic t_chan;
    ch_ack = 1'b1;
    chan_xfer(7'h2B, 8'h96, 1'b0, 1'b0);
    ch_ack = 1'b0;
    chan_xfer(7'h2B, 8'h96, 1'b1, 1'b0);
    ch_ack = 1'b1;
    // Rival master contends only inside the first address bit, never with a start or stop
    ch_grab = 1'b1;
    chan_xfer(7'h55, 8'h0F, 1'b0, 1'b1);
  endtask

  initial
  begin
    srst = 1'b1;
    strap_level = 3'h0;
    {rem_req, rem_we, rem_addr, rem_wdata} = '0;
    {chan_req, chan_addr, chan_data} = '0;
    {ch_ack, ch_grab, od_bad} = '0;
    t_strap;
    t_write;
    t_read;
    t_nomatch;
    t_prog;
    // Channel is used only once local traffic has ended, one direction at a time
    t_chan;
    check("open_drain", {7'h0, od_bad}, 8'h00);
    stop_test;
  end
endmodule
